// *** hdl/sefm_cfg.svh ***
`ifndef SEFM_CFG_SVH
`define SEFM_CFG_SVH

// register indices; byte address is four times the index
`define SEFM_IDX_LINK_FLAGS   8'h7C
`define SEFM_IDX_EVENT_EN     8'h7D
`define SEFM_IDX_ACL_FLAGS    8'h7E
`define SEFM_IDX_ACL_EN       8'h7F
`define SEFM_ADDR_W           10
`define SEFM_DATA_W           32
`define SEFM_REG_W            8
`define SEFM_WAKE_BIT         4
`define SEFM_FLAG_W           5
`define SEFM_LINK_PORTS       4
`define SEFM_ACL_PORTS        5
`define SEFM_RST_BYTE         8'h00
`define SEFM_RST_WORD         32'h0000_0000

`endif

// *** hdl/sefm_pkg.sv ***
`include "sefm_cfg.svh"

package sefm_pkg;

    typedef struct packed {
        logic                        psel;
        logic                        penable;
        logic                        pwrite;
        logic [`SEFM_ADDR_W-1:0]     paddr;
        logic [`SEFM_DATA_W-1:0]     pwdata;
    } sefm_apb_req_t;

    typedef struct packed {
        logic                        pready;
        logic                        pslverr;
        logic [`SEFM_DATA_W-1:0]     prdata;
    } sefm_apb_rsp_t;

    typedef enum logic [2:0] {
        SEFM_SEL_LINK = 3'b000,
        SEFM_SEL_EN   = 3'b001,
        SEFM_SEL_ACL  = 3'b010,
        SEFM_SEL_AEN  = 3'b011,
        SEFM_SEL_NONE = 3'b100
    } sefm_sel_t;

endpackage : sefm_pkg

// *** hdl/sefm_top.sv ***
// Summary of operation
// [R1] port 2 link change sets flag bit 1; write one clears; resets 0.
// [R2] port 1 link change sets flag bit 0; write one clears; resets 0.
// [R3] enable register: bit 4 wake, bits 3..0 ports 4..1; reset 0.
// [R4] acl flags bits 4..0 read-only per port; bits 7..5 read zero.
// [R5] acl enables bits 4..0 read-write per port; reset 0.
// [R6] wake event sets flag bit 4; write one clears it.
// [R7] ports 4 and 3 link changes set bits 3 and 2; write one clears.
// [R8] irq high while any enabled flag is set, low otherwise.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "sefm_cfg.svh"

module sefm_top
    import sefm_pkg::*;
#(
    parameter int LINK_PORTS = `SEFM_LINK_PORTS,
    parameter int ACL_PORTS  = `SEFM_ACL_PORTS
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire sefm_apb_req_t          apb_req,
    output sefm_apb_rsp_t               apb_rsp,
    input  wire logic [LINK_PORTS-1:0]  link_up,
    input  wire logic                   wake_event,
    input  wire logic [ACL_PORTS-1:0]   acl_event,
    output logic                        irq
);

    if (LINK_PORTS != `SEFM_LINK_PORTS || ACL_PORTS != `SEFM_ACL_PORTS) begin
        $error("sefm_top: port counts fixed by register layout");
    end

    // byte address to register select
    function automatic sefm_sel_t decode(
        input logic [`SEFM_ADDR_W-1:0] addr
    );
        sefm_sel_t s;
        s = SEFM_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[`SEFM_ADDR_W-1:2])
                `SEFM_IDX_LINK_FLAGS: s = SEFM_SEL_LINK;
                `SEFM_IDX_EVENT_EN:   s = SEFM_SEL_EN;
                `SEFM_IDX_ACL_FLAGS:  s = SEFM_SEL_ACL;
                `SEFM_IDX_ACL_EN:     s = SEFM_SEL_AEN;
                default:              s = SEFM_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    logic [`SEFM_FLAG_W-1:0] link_flags_q;
    logic [`SEFM_FLAG_W-1:0] event_en_q;
    logic [ACL_PORTS-1:0]    acl_flags_q;
    logic [ACL_PORTS-1:0]    acl_en_q;
    logic [LINK_PORTS-1:0]   link_chg;
    sefm_sel_t               sel;
    logic                    wr_en;
    logic [`SEFM_FLAG_W-1:0] wr_ones;

    assign sel     = decode(apb_req.paddr);
    assign wr_en   = apb_req.psel & apb_req.penable & apb_rsp.pready
                     & apb_req.pwrite;
    assign wr_ones = apb_req.pwdata[`SEFM_FLAG_W-1:0];

    // link state from the phy side: three flops, stable when 2nd/3rd agree
    for (genvar p = 0; p < LINK_PORTS; p++) begin : g_link
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic stable_q;
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                s1_q     <= 1'b0;
                s2_q     <= 1'b0;
                s3_q     <= 1'b0;
                stable_q <= 1'b0;
            end else begin
                s1_q <= link_up[p];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    stable_q <= s3_q;
                end
            end
        end
        assign link_chg[p] = (s2_q == s3_q) && (s3_q != stable_q);
    end

    // set wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            link_flags_q <= `SEFM_FLAG_W'(`SEFM_RST_BYTE);
        end else begin
            // [R1] [R2] [R7] port flags
            // [R6] wake flag
            link_flags_q <= (link_flags_q
                             & ~((wr_en && sel == SEFM_SEL_LINK)
                                 ? wr_ones : '0))
                            | {wake_event, link_chg};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            event_en_q <= `SEFM_FLAG_W'(`SEFM_RST_BYTE);
            acl_en_q   <= ACL_PORTS'(`SEFM_RST_BYTE);
        end else if (wr_en) begin
            // [R3] event enables
            if (sel == SEFM_SEL_EN) begin
                event_en_q <= wr_ones;
            end
            // [R5] acl enables
            if (sel == SEFM_SEL_AEN) begin
                acl_en_q <= apb_req.pwdata[ACL_PORTS-1:0];
            end
        end
    end

    // acl flags follow the acl engine, which holds its own events
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acl_flags_q <= ACL_PORTS'(`SEFM_RST_BYTE);
        end else begin
            // [R4] read-only acl flags
            acl_flags_q <= acl_event;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            // [R8] enabled flags drive irq
            irq <= |(link_flags_q & event_en_q) | |(acl_flags_q & acl_en_q);
        end
    end

    // no wait state: data registered in setup, ready in the first access cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            apb_rsp.pready  <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.prdata  <= `SEFM_RST_WORD;
        end else begin
            apb_rsp.pready  <= apb_req.psel & ~apb_req.penable;
            apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable
                               & (sel == SEFM_SEL_NONE);
            apb_rsp.prdata  <= `SEFM_RST_WORD;
            if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
                // [R4] upper bits read zero
                case (sel)
                    SEFM_SEL_LINK: apb_rsp.prdata <= `SEFM_DATA_W'(link_flags_q);
                    SEFM_SEL_EN:   apb_rsp.prdata <= `SEFM_DATA_W'(event_en_q);
                    SEFM_SEL_ACL:  apb_rsp.prdata <= `SEFM_DATA_W'(acl_flags_q);
                    SEFM_SEL_AEN:  apb_rsp.prdata <= `SEFM_DATA_W'(acl_en_q);
                    default:       apb_rsp.prdata <= `SEFM_RST_WORD;
                endcase
            end
        end
    end

endmodule : sefm_top

// *** test/sefm_top_properties.sv ***
`timescale 1ns/10ps
module sefm_chk
    import sefm_pkg::*;
#(
    parameter int LINK_PORTS = 4,
    parameter int ACL_PORTS  = 5
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire sefm_apb_req_t         apb_req,
    input wire sefm_apb_rsp_t         apb_rsp,
    input wire logic [LINK_PORTS-1:0] link_up,
    input wire logic                  wake_event,
    input wire logic [ACL_PORTS-1:0]  acl_event,
    input wire logic                  irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic setup = apb_req.psel && !apb_req.penable;
    wire logic rdy = apb_rsp.pready;
    wire logic hit = apb_req.paddr[9:4] == 6'h1F && apb_req.paddr[1:0] == 2'h0;
    sequence rd_s(a);
        setup && !apb_req.pwrite && apb_req.paddr == a;
    endsequence
    sequence hz_s;
        rdy && apb_rsp.prdata[31:5] == 27'h0;
    endsequence
    chk_ready_pulse: assert property (setup |=> rdy ##1 !rdy)
        else $error("ready not one cycle");
    chk_bad_addr: assert property (setup && !hit |=> apb_rsp.pslverr)
        else $error("no error on bad address");
    chk_idle_zero: assert property (!rdy |-> apb_rsp.prdata == 32'h0)
        else $error("read data not zero when idle");
    chk_flag_bits: assert property (rd_s(10'h1F0) |=> hz_s)
        else $error("flag upper bits set");
    chk_en_bits: assert property (rd_s(10'h1F4) |=> hz_s)
        else $error("enable upper bits set");
    chk_acl_bits: assert property (rd_s(10'h1F8) |=> hz_s)
        else $error("acl flag upper bits set");
    chk_aen_bits: assert property (rd_s(10'h1FC) |=> hz_s)
        else $error("acl enable upper bits set");
    chk_irq_release: assert property ($rose(rst_n) |-> !irq)
        else $error("irq high after reset");
    chk_err_with_ready: assert property (apb_rsp.pslverr |-> rdy)
        else $error("error without ready");
endmodule : sefm_chk

bind sefm_top sefm_chk #(.LINK_PORTS(LINK_PORTS), .ACL_PORTS(ACL_PORTS))
    u_chk (.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .link_up(link_up), .wake_event(wake_event),
    .acl_event(acl_event), .irq(irq));

// *** test/switch_event_flag_mask_bench.sv ***
`timescale 1ns/10ps
module switch_event_flag_mask_bench;
    import sefm_pkg::*;
    typedef struct packed {logic [9:0] a; logic [31:0] x; logic e;} sefm_row_t;
    sefm_row_t rows [6] = '{'{10'h1F4, 32'h1F, 1'b0}, '{10'h1FC, 32'h1F, 1'b0},
        '{10'h1F8, 32'h0, 1'b0}, '{10'h1F0, 32'h0, 1'b0},
        '{10'h200, 32'h0, 1'b1}, '{10'h1F6, 32'h0, 1'b1}};
    logic core_clk = 0, rst_n = 0, wake = 0, e, irq;
    logic [3:0] link = 4'h0;
    logic [4:0] acl = 5'h0;
    logic [31:0] r;
    sefm_apb_req_t req = '0;
    sefm_apb_rsp_t rsp;
    int fails = 0, checked = 0;
    sefm_top dut (.core_clk(core_clk), .rst_n(rst_n), .apb_req(req),
        .apb_rsp(rsp), .link_up(link), .wake_event(wake),
        .acl_event(acl), .irq(irq));
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [9:0] a);
        req <= '{1'b1, 1'b0, w, a, 32'hFFFF_FFFF};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        // idle edge so req is never assigned twice in one step
        @(posedge core_clk);
    endtask : apb
    task automatic rd(input logic [9:0] a, input logic [31:0] x);
        apb(1'b0, a);
        chk(r, x);
    endtask : rd
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(10'h1F0 + 10'(4 * i), 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a);
            chk(32'(e), 32'(rows[i].e));
            rd(rows[i].a, rows[i].x);
        end
        wake <= 1'b1;
        @(posedge core_clk);
        wake <= 1'b0;
        rd(10'h1F0, 32'h10);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, 10'h1F0);
            link[p] <= 1'b1;
            repeat (8) @(posedge core_clk);
            rd(10'h1F0, 32'h1 << p);
            chk(32'(irq), 32'h1);
        end
        apb(1'b1, 10'h1F0);
        acl <= 5'h15;
        repeat (2) @(posedge core_clk);
        rd(10'h1F8, 32'h15);
        chk(32'(irq), 32'h1);
        acl <= 5'h0;
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        // mid-run reset with all links up: enables clear, links flag again
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(10'h1F4, 32'h0);
        chk(32'(irq), 32'h0);
        rd(10'h1FC, 32'h0);
        rd(10'h1F0, 32'hF);
        // wake held through the clearing write: set wins
        wake <= 1'b1;
        apb(1'b1, 10'h1F0);
        wake <= 1'b0;
        rd(10'h1F0, 32'h10);
        conclude();
    end
endmodule : switch_event_flag_mask_bench
